// ===== ccfs_host.sv
// host side model: offers one command at a time on the card link
// assumes the card clock runs free and every taken command is answered
`timescale 1ns/1ps
module ccfs_host
   import ccfs_pkg::*;
(
   input wire logic card_clk_in,
   input wire logic ready_in,
   input wire logic resp_valid_in,
   input wire logic [31:0] resp_word_in,
   output logic valid_out,
   output ccfs_req_t cmd_out
);
   // idle link at time zero
   initial begin
      valid_out = 1'b0;
      cmd_out = '0;
   end
   // offer, hold until taken, then wait for the answer
   task automatic send(input ccfs_cmd_t kind, input logic [31:0] arg,
                       output logic [31:0] word, output bit ok);
      int n;
      n = 0;
      @(negedge card_clk_in);
      valid_out = 1'b1;
      cmd_out = '{kind, arg};
      // ready read mid-cycle: it only moves after a rising edge
      while (ready_in !== 1'b1 && n < 400) begin
         @(negedge card_clk_in);
         n++;
      end
      @(posedge card_clk_in);
      @(negedge card_clk_in);
      valid_out = 1'b0;
      cmd_out = ~cmd_out; // released lines must not keep the last value
      while (resp_valid_in !== 1'b1 && n < 400) begin
         @(negedge card_clk_in);
         n++;
      end
      word = resp_word_in;
      ok = (n < 400);
   endtask : send
endmodule : ccfs_host

// ===== ccfs_pkg.sv
// package for the card configuration and status bank: layouts, codes, decoders
// assumes the user sees the configuration word as one 128-bit packed struct
package ccfs_pkg;

   // command kinds seen on the card link
   typedef enum logic [2:0] {
      CMD_STATUS,
      CMD_SET_BLEN,
      CMD_WRITE,
      CMD_ERASE_START,
      CMD_ERASE_END,
      CMD_ERASE,
      CMD_PROG_CONFIG,
      CMD_SET_PROTECT
   } ccfs_cmd_t;

   // erase sequence tracking
   typedef enum logic [1:0] {
      ER_IDLE,
      ER_START,
      ER_END
   } ccfs_erase_t;

   // one command as latched at the link
   typedef struct packed {
      ccfs_cmd_t kind;
      logic [31:0] arg;
   } ccfs_req_t;

   // configuration word, msb first
   typedef struct packed {
      logic [1:0] structure_version;
      logic [3:0] protocol_version;
      logic [1:0] rsv_125;
      logic [7:0] read_access_time;
      logic [7:0] clock_access_units;
      logic [7:0] transfer_speed;
      logic [11:0] command_classes;
      logic [3:0] read_block_length_code;
      logic short_read_blocks_ok;
      logic write_misalign_ok;
      logic read_misalign_ok;
      logic driver_stage_present;
      logic [1:0] rsv_75;
      logic [11:0] device_size;
      logic [2:0] read_current_min_code;
      logic [2:0] read_current_max_code;
      logic [2:0] write_current_min_code;
      logic [2:0] write_current_max_code;
      logic [2:0] capacity_multiplier_code;
      logic [4:0] sector_size_code;
      logic [4:0] erase_group_sectors;
      logic [4:0] protect_group_span;
      logic group_protect_allowed;
      logic [1:0] default_ecc_code;
      logic [2:0] program_time_factor;
      logic [3:0] write_block_length_code;
      logic short_write_blocks_ok;
      logic [4:0] rsv_20;
      logic format_group;
      logic copy_bit;
      logic permanent_lock_bit;
      logic temporary_lock_bit;
      logic [1:0] file_format;
      logic [1:0] ecc_type;
      logic [6:0] checksum;
      logic always_one;
   } ccfs_cfg_t;

   // decoded view of the configuration word
   typedef struct packed {
      logic [10:0] read_min_dma;    // tenths of mA
      logic [10:0] write_min_dma;
      logic [10:0] read_max_dma;
      logic [10:0] write_max_dma;
      logic [9:0] capacity_factor;
      logic [5:0] sector_blocks;
      logic [5:0] group_sectors;
      logic [5:0] protect_groups;
      logic [5:0] program_time_capacity_factor;  // zero on reserved code
      logic [11:0] read_block_bytes;  // zero on reserved code
      logic [11:0] write_block_bytes;
      logic ecc_type_valid;
      logic default_ecc_valid;
      logic write_locked;
   } ccfs_info_t;

   localparam logic [127:0] CFG_RESET = 128'h1;
   localparam logic [3:0] BLOCK_LEN_MAX_CODE = 4'hB;
   localparam logic [2:0] R2W_MAX_CODE = 3'h5;
   localparam logic [1:0] ECC_MAX_CODE = 2'h1;
   localparam logic [4:0] CAPACITY_FACTOR_OFFSET = 5'h2;
   // status word layout
   localparam int ST_ERR_MSB = 31;
   localparam int ST_ERR_LSB = 28;
   localparam int ST_STATE_MSB = 12;
   localparam int ST_STATE_LSB = 9;
   // error vector index, bit 3 lands on status bit 31
   localparam int ERR_RANGE = 3;
   localparam int ERR_MISALIGN = 2;
   localparam int ERR_BLEN = 1;
   localparam int ERR_ERASE_SEQ = 0;
   // program-config argument: low 16 bits of the word
   localparam int PROG_COPY_BIT = 14;
   localparam int PROG_PERM_BIT = 13;
   localparam int PROG_TEMP_BIT = 12;

   // minimum supply current, tenths of mA
   function automatic logic [10:0] ccfs_min_current(input logic [2:0] code);
      case (code)
         3'h0: return 11'h005;
         3'h1: return 11'h00A;
         3'h2: return 11'h032;
         3'h3: return 11'h064;
         3'h4: return 11'h0FA;
         3'h5: return 11'h15E;
         3'h6: return 11'h258;
         default: return 11'h3E8;
      endcase
   endfunction : ccfs_min_current

   // maximum supply current, tenths of mA
   function automatic logic [10:0] ccfs_max_current(input logic [2:0] code);
      case (code)
         3'h0: return 11'h00A;
         3'h1: return 11'h032;
         3'h2: return 11'h064;
         3'h3: return 11'h0FA;
         3'h4: return 11'h15E;
         3'h5: return 11'h1C2;
         3'h6: return 11'h320;
         default: return 11'h7D0;
      endcase
   endfunction : ccfs_max_current

   // power-of-two block length, zero for reserved codes
   function automatic logic [11:0] ccfs_block_bytes(input logic [3:0] code);
      if (code > BLOCK_LEN_MAX_CODE) begin
         return 12'h000;
      end
      return 12'h001 << code;
   endfunction : ccfs_block_bytes

endpackage : ccfs_pkg

// ===== ccfs_regs.sv
// card configuration word and status error bits, with the command link front end
// assumes the host holds the link clock running until each response has come back
`timescale 1ns/1ps
module ccfs_regs (
   input wire logic CLK_IN,
   input wire logic RST_N_IN,
   input wire logic CARD_CLK_IN,
   input wire logic CMD_VALID_IN,
   input wire ccfs_pkg::ccfs_req_t CMD_IN,
   output logic CMD_READY_OUT,
   output logic RESP_VALID_OUT,
   output logic [31:0] RESP_WORD_OUT,
   input wire ccfs_pkg::ccfs_cfg_t NV_CONFIG_IN,
   input wire logic [3:0] CARD_STATE_IN,
   output ccfs_pkg::ccfs_cfg_t CONFIG_OUT,
   output ccfs_pkg::ccfs_info_t CONFIG_INFO_OUT,
   output logic ACCESS_GO_OUT,
   output ccfs_pkg::ccfs_cmd_t ACCESS_KIND_OUT,
   output logic [31:0] ACCESS_ADDR_OUT
);
   import ccfs_pkg::*;

   // link domain
   logic link_rst_n;          // reset as seen on the card clock
   logic busy_r;              // command held, waiting for the core
   logic req_tgl_r;           // flips once per accepted command
   ccfs_req_t req_hold_r;     // stable while busy
   logic ack_sync;            // core ack toggle, synchronised
   logic ack_seen_r;
   logic ack_edge;
   logic [31:0] resp_out_r;
   logic resp_valid_r;

   // core domain
   logic req_sync;            // link request toggle, synchronised
   logic req_seen_r;
   logic new_req;             // one-cycle: command to process
   logic ack_tgl_r;
   logic [31:0] core_resp_r;  // held until the next command
   logic load_done_r;         // power-up copy taken
   ccfs_cfg_t cfg_r;
   ccfs_info_t info_r;
   ccfs_erase_t erase_r;
   logic [3:0] err_r;         // status bits 31..28
   logic [3:0] new_err;
   logic go_r;
   ccfs_cmd_t go_kind_r;
   logic [31:0] go_addr_r;

   // decode of the current command
   logic is_addr_cmd;
   logic [4:0] cap_shift;
   logic [39:0] cap_bytes;
   logic [11:0] wblen;
   logic [31:0] wblen_w;
   logic lock;
   logic range_err;
   logic mis_err;
   logic blen_err;
   logic seq_err;
   logic grant;

   // crossings: reset into link, toggles both ways
   ccfs_sync2 u_link_rst (
      .clk_in(CARD_CLK_IN),
      .rst_n_in(1'b1),
      .d_in(RST_N_IN),
      .q_out(link_rst_n)
   );

   ccfs_sync2 u_req_sync (
      .clk_in(CLK_IN),
      .rst_n_in(RST_N_IN),
      .d_in(req_tgl_r),
      .q_out(req_sync)
   );

   ccfs_sync2 u_ack_sync (
      .clk_in(CARD_CLK_IN),
      .rst_n_in(link_rst_n),
      .d_in(ack_tgl_r),
      .q_out(ack_sync)
   );

   assign ack_edge = ack_sync ^ ack_seen_r;
   assign CMD_READY_OUT = ~busy_r;

   // link: accept one command, hold it until the ack returns
   always_ff @(posedge CARD_CLK_IN) begin
      if (!link_rst_n) begin
         busy_r <= 1'b0;
         req_tgl_r <= 1'b0;
         req_hold_r <= '0;
      end else if (CMD_VALID_IN && !busy_r) begin
         req_hold_r <= CMD_IN;
         req_tgl_r <= ~req_tgl_r;
         busy_r <= 1'b1;
      end else if (ack_edge) begin
         busy_r <= 1'b0;
      end
   end

   // link: response word taken while the core holds it stable
   always_ff @(posedge CARD_CLK_IN) begin
      if (!link_rst_n) begin
         ack_seen_r <= 1'b0;
         resp_out_r <= 32'h0;
         resp_valid_r <= 1'b0;
      end else begin
         ack_seen_r <= ack_sync;
         resp_valid_r <= ack_edge;
         if (ack_edge) begin
            resp_out_r <= core_resp_r;
         end
      end
   end

   assign RESP_VALID_OUT = resp_valid_r;
   assign RESP_WORD_OUT = resp_out_r;

   // core: commands wait until the power-up copy is in
   assign new_req = (req_sync ^ req_seen_r) & load_done_r;

   // command checks, all known at response time
   always_comb begin
      is_addr_cmd = (req_hold_r.kind == CMD_WRITE) || (req_hold_r.kind == CMD_ERASE_START)
                    || (req_hold_r.kind == CMD_ERASE_END);
      cap_shift = 5'(cfg_r.capacity_multiplier_code) + CAPACITY_FACTOR_OFFSET
                  + 5'(cfg_r.read_block_length_code);
      cap_bytes = (40'(cfg_r.device_size) + 40'h1) << cap_shift;
      wblen = ccfs_block_bytes(cfg_r.write_block_length_code);
      wblen_w = 32'(wblen);
      lock = cfg_r.permanent_lock_bit | cfg_r.temporary_lock_bit;
      range_err = is_addr_cmd && ({8'h00, req_hold_r.arg} >= cap_bytes);
      // with short blocks allowed any write may start anywhere; otherwise writes must be block aligned
      mis_err = (req_hold_r.kind == CMD_WRITE) && !cfg_r.short_write_blocks_ok
                && ((req_hold_r.arg & (wblen_w - 32'h1)) != 32'h0);
      blen_err = ((req_hold_r.kind == CMD_SET_BLEN)
                  && ((req_hold_r.arg == 32'h0) || (req_hold_r.arg > wblen_w)
                      || (!cfg_r.short_write_blocks_ok && (req_hold_r.arg != wblen_w))))
                 || ((req_hold_r.kind == CMD_WRITE) && (wblen == 12'h000));
      seq_err = ((req_hold_r.kind == CMD_ERASE_END) && (erase_r != ER_START))
                || ((req_hold_r.kind == CMD_ERASE) && (erase_r != ER_END));
      new_err = 4'h0;
      if (new_req) begin
         new_err[ERR_RANGE] = range_err;
         new_err[ERR_MISALIGN] = mis_err;
         new_err[ERR_BLEN] = blen_err;
         new_err[ERR_ERASE_SEQ] = seq_err;
      end
      grant = 1'b0;
      if (new_req && !lock) begin
         case (req_hold_r.kind)
            CMD_WRITE: grant = !range_err && !mis_err && !blen_err;
            CMD_ERASE: grant = !seq_err;
            CMD_SET_PROTECT: grant = cfg_r.group_protect_allowed;
            default: grant = 1'b0;
         endcase
      end
   end

   // core: handshake bookkeeping and the response word
   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
         req_seen_r <= 1'b0;
         ack_tgl_r <= 1'b0;
         core_resp_r <= 32'h0;
      end else if (new_req) begin
         req_seen_r <= req_sync;
         ack_tgl_r <= ~ack_tgl_r;
         // sticky bits plus this command's own findings
         core_resp_r <= '0;
         core_resp_r[ST_ERR_MSB:ST_ERR_LSB] <= err_r | new_err;
         core_resp_r[ST_STATE_MSB:ST_STATE_LSB] <= CARD_STATE_IN;
      end
   end

   // core: error bits, read clears, a new error in the same cycle wins
   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
         err_r <= 4'h0;
      end else if (new_req && (req_hold_r.kind == CMD_STATUS)) begin
         err_r <= new_err;
      end else begin
         err_r <= err_r | new_err;
      end
   end

   // core: erase start, end, erase must come in that order
   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
         erase_r <= ER_IDLE;
      end else if (new_req) begin
         case (req_hold_r.kind)
            CMD_ERASE_START: erase_r <= range_err ? ER_IDLE : ER_START;
            CMD_ERASE_END: erase_r <= (seq_err || range_err) ? ER_IDLE : ER_END;
            CMD_ERASE: erase_r <= ER_IDLE;
            default: erase_r <= erase_r;
         endcase
      end
   end

   // core: power-up copy, then program-config updates
   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
         cfg_r <= CFG_RESET;
         load_done_r <= 1'b0;
      end else if (!load_done_r) begin
         cfg_r <= NV_CONFIG_IN;
         load_done_r <= 1'b1;
      end else if (new_req && (req_hold_r.kind == CMD_PROG_CONFIG)) begin
         // checksum is stored as given; keeping it right is the host's job
         cfg_r.checksum <= req_hold_r.arg[7:1];
         cfg_r.ecc_type <= req_hold_r.arg[9:8];
         cfg_r.file_format <= req_hold_r.arg[11:10];
         cfg_r.format_group <= req_hold_r.arg[15];
         cfg_r.temporary_lock_bit <= req_hold_r.arg[PROG_TEMP_BIT];
         // one-way bits: a clear attempt is silently ignored
         cfg_r.copy_bit <= cfg_r.copy_bit | req_hold_r.arg[PROG_COPY_BIT];
         cfg_r.permanent_lock_bit <= cfg_r.permanent_lock_bit
                                     | req_hold_r.arg[PROG_PERM_BIT];
      end
   end

   // core: decoded field view, one cycle behind the word
   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
         info_r <= '0;
      end else begin
         info_r.read_min_dma <= ccfs_min_current(cfg_r.read_current_min_code);
         info_r.write_min_dma <= ccfs_min_current(cfg_r.write_current_min_code);
         info_r.read_max_dma <= ccfs_max_current(cfg_r.read_current_max_code);
         info_r.write_max_dma <= ccfs_max_current(cfg_r.write_current_max_code);
         info_r.capacity_factor <= 10'h001 << (4'(cfg_r.capacity_multiplier_code)
                                               + 4'(CAPACITY_FACTOR_OFFSET));
         info_r.sector_blocks <= 6'(cfg_r.sector_size_code) + 6'h01;
         info_r.group_sectors <= 6'(cfg_r.erase_group_sectors) + 6'h01;
         info_r.protect_groups <= 6'(cfg_r.protect_group_span) + 6'h01;
         info_r.program_time_capacity_factor <= (cfg_r.program_time_factor > R2W_MAX_CODE) ? 6'h00
                                     : (6'h01 << cfg_r.program_time_factor);
         info_r.read_block_bytes <= ccfs_block_bytes(cfg_r.read_block_length_code);
         info_r.write_block_bytes <= wblen;
         info_r.ecc_type_valid <= (cfg_r.ecc_type <= ECC_MAX_CODE);
         info_r.default_ecc_valid <= (cfg_r.default_ecc_code <= ECC_MAX_CODE);
         info_r.write_locked <= lock;
      end
   end

   // core: granted accesses go to the memory engine
   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
         go_r <= 1'b0;
         go_kind_r <= CMD_STATUS;
         go_addr_r <= 32'h0;
      end else begin
         go_r <= grant;
         if (grant) begin
            go_kind_r <= req_hold_r.kind;
            go_addr_r <= req_hold_r.arg;
         end
      end
   end

   assign CONFIG_OUT = cfg_r;
   assign CONFIG_INFO_OUT = info_r;
   assign ACCESS_GO_OUT = go_r;
   assign ACCESS_KIND_OUT = go_kind_r;
   assign ACCESS_ADDR_OUT = go_addr_r;

   // checks on the core clock; the response strobe check and cover run on the link clock
   a_lock_blocks_go: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
      go_r && (go_kind_r != CMD_SET_PROTECT) |-> !$past(lock))
      else $error("write or erase granted while locked");
   a_group_needs_enable: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
      go_r && (go_kind_r == CMD_SET_PROTECT) |-> $past(cfg_r.group_protect_allowed))
      else $error("group protect granted while not allowed");
   a_copy_stays_set: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
      $past(load_done_r) && $past(cfg_r.copy_bit) |-> cfg_r.copy_bit)
      else $error("copy bit returned to original");
   a_perm_lock_stays: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
      $past(load_done_r) && $past(cfg_r.permanent_lock_bit) |-> cfg_r.permanent_lock_bit)
      else $error("permanent lock cleared");
   a_range_sticks: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
      new_req && range_err |=> err_r[ERR_RANGE] && core_resp_r[ST_ERR_MSB])
      else $error("out of range not flagged");
   a_misalign_flag: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
      new_req && mis_err |=> core_resp_r[ST_ERR_MSB - 1] && !go_r)
      else $error("misaligned write not flagged or still granted");
   a_blen_flag: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
      new_req && blen_err |=> err_r[ERR_BLEN] ##1 err_r[ERR_BLEN] || $past(new_req))
      else $error("block length error lost");
   a_erase_order: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
      new_req && (req_hold_r.kind == CMD_ERASE) && (erase_r != ER_END)
      |=> core_resp_r[ST_ERR_LSB] && !go_r && (erase_r == ER_IDLE))
      else $error("erase out of sequence not caught");
   a_status_read_clears: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
      new_req && (req_hold_r.kind == CMD_STATUS) && (err_r != 4'h0)
      |=> (err_r == 4'h0) && (core_resp_r[ST_ERR_MSB:ST_ERR_LSB] == $past(err_r)))
      else $error("status read did not report then clear");
   a_state_snapshot: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
      new_req |=> core_resp_r[ST_STATE_MSB:ST_STATE_LSB] == $past(CARD_STATE_IN))
      else $error("state field not taken at command receipt");
   a_resp_one_cycle: assert property (@(posedge CARD_CLK_IN) disable iff (!link_rst_n)
      resp_valid_r |-> !busy_r ##1 !resp_valid_r)
      else $error("response strobe longer than one cycle");

   c_write_granted: cover property (@(posedge CLK_IN) disable iff (!RST_N_IN)
      go_r && (go_kind_r == CMD_WRITE));
   c_erase_done: cover property (@(posedge CLK_IN) disable iff (!RST_N_IN)
      go_r && (go_kind_r == CMD_ERASE));
   c_status_clear: cover property (@(posedge CLK_IN) disable iff (!RST_N_IN)
      new_req && (req_hold_r.kind == CMD_STATUS) && (err_r != 4'h0));
   c_link_resp: cover property (@(posedge CARD_CLK_IN) disable iff (!link_rst_n)
      resp_valid_r);
endmodule : ccfs_regs

// ===== ccfs_regs_tb.sv
// testbench for the card configuration and status bank
// assumes core clock 50 ns, link clock 6 ns, host model on the link
`timescale 1ns/1ps
module ccfs_regs_tb;
   import ccfs_pkg::*;
   logic clk = 1'b0;
   logic card_clk = 1'b0;
   logic rst_n = 1'b0;
   logic cmd_valid, ready, resp_valid, go;
   logic [31:0] resp_word, addr;
   logic [3:0] state = 4'h4; // card state fed to the bank
   ccfs_req_t cmd;
   ccfs_cfg_t nv, cfg;
   ccfs_info_t info, ei;
   ccfs_cmd_t kind;
   int miscompares = 0;
   int tests_run = 0;
   int grants = 0; // granted accesses seen
   always #25 clk = ~clk;
   always #3 card_clk = ~card_clk;
   // count grant pulses on the core side
   always @(posedge clk) if (go === 1'b1) grants++;
   ccfs_host i_host (.card_clk_in(card_clk), .ready_in(ready), .resp_valid_in(resp_valid),
      .resp_word_in(resp_word), .valid_out(cmd_valid), .cmd_out(cmd));
   ccfs_regs i_dut (.CLK_IN(clk), .RST_N_IN(rst_n), .CARD_CLK_IN(card_clk),
      .CMD_VALID_IN(cmd_valid), .CMD_IN(cmd), .CMD_READY_OUT(ready),
      .RESP_VALID_OUT(resp_valid), .RESP_WORD_OUT(resp_word), .NV_CONFIG_IN(nv),
      .CARD_STATE_IN(state), .CONFIG_OUT(cfg), .CONFIG_INFO_OUT(info),
      .ACCESS_GO_OUT(go), .ACCESS_KIND_OUT(kind), .ACCESS_ADDR_OUT(addr));
   // verdict and end of run
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : give_verdict
   // one comparison
   task automatic chk(input logic [127:0] got, input logic [127:0] exp);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   // command with expected error bits and grant count
   task automatic run(input ccfs_cmd_t k, input logic [31:0] a, input logic [31:0] e,
                      input int g);
      logic [31:0] w;
      bit ok;
      i_host.send(k, a, w, ok);
      repeat (4) @(negedge clk); // grant lands after the answer
      chk(ok, 1'b1);
      chk(w, e | {19'h0, state, 9'h0});
      chk(grants, g);
   endtask : run
   // watchdog, far beyond the expected run
   initial begin
      #200000;
      miscompares++;
      give_verdict();
   end
   initial begin
      nv = '0;
      nv.always_one = 1'b1;
      nv.read_block_length_code = 4'h9;
      nv.write_block_length_code = 4'h9;
      nv.read_current_min_code = 3'h7;
      nv.read_current_max_code = 3'h7;
      nv.write_current_max_code = 3'h5;
      nv.capacity_multiplier_code = 3'h7;
      nv.sector_size_code = 5'h1F;
      nv.protect_group_span = 5'h4;
      nv.program_time_factor = 3'h5;
      nv.ecc_type = 2'h1;
      nv.default_ecc_code = 2'h2;
      ei = '0;
      ei.read_min_dma = 11'h3E8;
      ei.write_min_dma = 11'h005;
      ei.read_max_dma = 11'h7D0;
      ei.write_max_dma = 11'h1C2;
      ei.capacity_factor = 10'h200;
      ei.sector_blocks = 6'h20;
      ei.group_sectors = 6'h01;
      ei.protect_groups = 6'h05;
      ei.program_time_capacity_factor = 6'h20;
      ei.read_block_bytes = 12'h200;
      ei.write_block_bytes = 12'h200;
      ei.ecc_type_valid = 1'b1;
      repeat (5) @(negedge clk);
      chk(cfg, 128'h1);
      chk(resp_word, 32'h0);
      rst_n = 1'b1;
      repeat (4) @(negedge clk);
      chk(cfg, nv);
      chk(info, ei);
      $display("reset and decode done");
      run(CMD_WRITE, 32'h200, 32'h0, 1);
      chk(addr, 32'h200);
      chk(kind, CMD_WRITE);
      run(CMD_WRITE, 32'h201, 32'h40000000, 1);
      run(CMD_SET_BLEN, 32'h64, 32'h60000000, 1);
      run(CMD_STATUS, 32'h0, 32'h60000000, 1);
      run(CMD_STATUS, 32'h0, 32'h0, 1);
      run(CMD_WRITE, 32'h40000, 32'h80000000, 1);
      run(CMD_ERASE, 32'h0, 32'h90000000, 1);
      run(CMD_STATUS, 32'h0, 32'h90000000, 1);
      state = 4'h9;
      run(CMD_ERASE_START, 32'h0, 32'h0, 1);
      run(CMD_ERASE_END, 32'h0, 32'h0, 1);
      run(CMD_ERASE, 32'h0, 32'h0, 2);
      run(CMD_SET_PROTECT, 32'h0, 32'h0, 2);
      $display("status and erase done");
      // leave a sticky error behind, then power up again from a different stored word
      run(CMD_WRITE, 32'h201, 32'h40000000, 2);
      rst_n = 1'b0;
      nv.group_protect_allowed = 1'b1;
      nv.short_write_blocks_ok = 1'b1;
      nv.program_time_factor = 3'h6;
      nv.read_block_length_code = 4'hC;
      ei.program_time_capacity_factor = 6'h00;
      ei.read_block_bytes = 12'h000;
      repeat (5) @(negedge clk);
      rst_n = 1'b1;
      repeat (4) @(negedge clk);
      chk(cfg, nv);
      chk(info, ei);
      run(CMD_STATUS, 32'h0, 32'h0, 2);
      run(CMD_SET_PROTECT, 32'h0, 32'h0, 3);
      chk(kind, CMD_SET_PROTECT);
      run(CMD_WRITE, 32'h201, 32'h0, 4);
      chk(addr, 32'h201);
      $display("second power-up done");
      run(CMD_PROG_CONFIG, 32'h5301, 32'h0, 4);
      chk({cfg.copy_bit, cfg.temporary_lock_bit, info.write_locked}, 3'h7);
      chk(info.ecc_type_valid, 1'b0);
      run(CMD_WRITE, 32'h0, 32'h0, 4);
      run(CMD_PROG_CONFIG, 32'h00A5, 32'h0, 4);
      chk({cfg.copy_bit, cfg.temporary_lock_bit}, 2'h2);
      chk(cfg.checksum, 7'h52);
      run(CMD_WRITE, 32'h0, 32'h0, 5);
      run(CMD_PROG_CONFIG, 32'h2001, 32'h0, 5);
      run(CMD_PROG_CONFIG, 32'h0001, 32'h0, 5);
      chk(cfg.permanent_lock_bit, 1'b1);
      run(CMD_ERASE_START, 32'h0, 32'h0, 5);
      run(CMD_ERASE_END, 32'h0, 32'h0, 5);
      run(CMD_ERASE, 32'h0, 32'h0, 5);
      run(CMD_WRITE, 32'h0, 32'h0, 5);
      $display("locks done");
      give_verdict();
   end
endmodule : ccfs_regs_tb

// ===== ccfs_sync2.sv
// two-flop level synchroniser
// assumes d is a slow level or toggle from another clock domain
`timescale 1ns/1ps
module ccfs_sync2 (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic d_in,
   output logic q_out
);
   logic meta_r; // first stage, read only by the second
   logic hold_r; // second stage

   // both stages clear together on reset
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         meta_r <= 1'b0;
         hold_r <= 1'b0;
      end else begin
         meta_r <= d_in;
         hold_r <= meta_r;
      end
   end

   assign q_out = hold_r;
endmodule : ccfs_sync2
